// File: hw/boot_loader_pkg.sv
`default_nettype none
package boot_loader_pkg;
  // Clock rate and start-up wait before rate measurement
  localparam int CLK_HZ = 20_000_000;
  localparam int STARTUP_STATES = 100;
  localparam int STARTUP_CYCLES = STARTUP_STATES;
  // Width of measurement and baud counters
  localparam int DIV_W = 16;
  // Low bits in a zero byte: start bit plus eight data bits
  localparam int LOW_BITS = 9;
  // Strap levels two, one, zero selecting serial boot
  localparam logic [2:0] BOOT_STRAPS = 3'h3;
  // Handshake bytes
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_SYNC = 8'h55;
  localparam logic [7:0] BYTE_ACK = 8'hAA;
  localparam logic [7:0] BYTE_FAIL = 8'hFF;
  // On-chip RAM map
  localparam logic [23:0] LOADER_RAM_BASE = 24'hFF8000;
  localparam logic [23:0] LOADER_RAM_TOP = 24'hFF87FF;
  localparam logic [23:0] PROG_RAM_BASE = 24'hFF8800;
  localparam logic [23:0] PROG_RAM_TOP = 24'hFFBFFF;
  // Register byte offsets
  localparam logic [7:0] REG_SERIAL_CTRL = 8'h00;
  localparam logic [7:0] REG_BAUD_DIV = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_LENGTH = 8'h0C;
  localparam logic [7:0] REG_COUNT = 8'h10;
  // Field positions in serial_ctrl_reg and status
  localparam int CTRL_RX_ON_BIT = 0;
  localparam int CTRL_TX_ON_BIT = 1;
  localparam int STAT_BRANCH_BIT = 4;
  localparam int STAT_FAIL_BIT = 5;
  localparam int STAT_IRQ_BLOCK_BIT = 6;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Loader sequence
  typedef enum logic [3:0] {
    ST_STARTUP = 4'h0,
    ST_NOT_BOOT = 4'h1,
    ST_MEAS_IDLE = 4'h2,
    ST_MEAS_LOW = 4'h3,
    ST_SEND = 4'h4,
    ST_WAIT_SYNC = 4'h5,
    ST_LEN_HI = 4'h6,
    ST_LEN_LO = 4'h7,
    ST_DATA = 4'h8,
    ST_CHECK = 4'h9,
    ST_ERASE = 4'hA,
    ST_HALT = 4'hB,
    ST_BRANCHED = 4'hC
  } loader_state_t;
endpackage
`default_nettype wire

// File: hw/serial_boot_loader.sv
`timescale 1ns/1ns
`default_nettype none
module serial_boot_loader
  import boot_loader_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd_pin,
  output logic txd_pin,
  input wire logic [2:0] op_mode_pins,
  input wire logic watchdog_overflow,
  output logic flash_check_req,
  input wire logic flash_check_done,
  input wire logic flash_blank,
  output logic flash_erase_req,
  input wire logic flash_erase_done,
  input wire logic flash_erase_ok,
  output logic ram_we,
  output logic [23:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic branch_go,
  output logic irq_block
);
  // Whole module state
  typedef struct packed {
    loader_state_t state;
    loader_state_t ret; // State after a send
    logic [2:0] strap_s1; // Strap synchroniser
    logic [2:0] strap_s2;
    logic rx_s1; // Receive line synchroniser
    logic rx_s2;
    logic [DIV_W-1:0] cnt; // Start-up counter
    logic [3:0] pre; // Divide-by-nine prescaler
    logic [DIV_W-1:0] div; // baud_divisor_reg
    logic rx_on; // rx_on_flag
    logic tx_on; // tx_on_flag
    logic tx_start;
    logic [7:0] tx_data;
    logic sent;
    logic pend; // Received byte not yet used
    logic [7:0] pend_data;
    logic [15:0] len; // Program length
    logic [15:0] idx; // Bytes received
    logic ram_we;
    logic [23:0] ram_addr;
    logic [7:0] ram_wdata;
    logic check;
    logic erase;
    logic flash_ok;
    logic fail;
    logic branch;
    logic irq_block;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } loader_t;
  loader_t r;
  loader_t next_r;

  serial_link_if lk ();

  // Serial receiver on the synchronised line
  serial_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .lk(lk.rx)
  );

  // Serial transmitter drives the pin from its own flop
  serial_tx u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .lk(lk.tx),
    .txd_pin(txd_pin)
  );

  assign lk.div = r.div;
  assign lk.rx_on = r.rx_on;
  assign lk.tx_on = r.tx_on;
  assign lk.rx_line = r.rx_s2;
  assign lk.tx_start = r.tx_start;
  assign lk.tx_data = r.tx_data;

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign flash_check_req = r.check;
  assign flash_erase_req = r.erase;
  assign ram_we = r.ram_we;
  assign ram_addr = r.ram_addr;
  assign ram_wdata = r.ram_wdata;
  assign branch_go = r.branch;
  assign irq_block = r.irq_block;

  // Queue one byte for the transmitter, then go to ret
  function automatic loader_t go_send(loader_t s, logic [7:0] b,
                                      loader_state_t ret);
    s.state = ST_SEND;
    s.tx_data = b;
    s.ret = ret;
    s.sent = 1'b0;
    return s;
  endfunction

  // Register read mux
  function automatic logic [32:0] read_reg(loader_t s,
                                           logic [ADDR_W-1:0] a);
    logic [31:0] d;
    logic hit;
    d = '0;
    hit = 1'b1;
    case (a)
      ADDR_W'(REG_SERIAL_CTRL): begin
        d[CTRL_RX_ON_BIT] = s.rx_on;
        d[CTRL_TX_ON_BIT] = s.tx_on;
      end
      ADDR_W'(REG_BAUD_DIV): d[DIV_W-1:0] = s.div;
      ADDR_W'(REG_STATUS): begin
        d[3:0] = s.state;
        d[STAT_BRANCH_BIT] = s.branch;
        d[STAT_FAIL_BIT] = s.fail;
        d[STAT_IRQ_BLOCK_BIT] = s.irq_block;
      end
      ADDR_W'(REG_LENGTH): d[15:0] = s.len;
      ADDR_W'(REG_COUNT): d[15:0] = s.idx;
      default: hit = 1'b0;
    endcase
    return {hit, d};
  endfunction

  // Loader sequence, serial handshake and bus slave
  always_comb begin
    logic [32:0] rd;
    rd = '0;
    next_r = r;
    next_r.strap_s1 = op_mode_pins;
    next_r.strap_s2 = r.strap_s1;
    next_r.rx_s1 = rxd_pin;
    next_r.rx_s2 = r.rx_s1;
    next_r.tx_start = 1'b0;
    next_r.ram_we = 1'b0;
    // A new byte always lands, even while the old is taken
    if (lk.rx_valid) begin
      next_r.pend = 1'b1;
      next_r.pend_data = lk.rx_data;
    end
    case (r.state)
      ST_STARTUP: begin
        // Straps are sampled well after reset release
        if (r.cnt == DIV_W'(STARTUP_CYCLES - 1)) begin
          next_r.state = (r.strap_s2 == BOOT_STRAPS) ? ST_MEAS_IDLE
                                                     : ST_NOT_BOOT;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_MEAS_IDLE: begin
        // Wait for a falling edge from an idle-high line
        if (!r.rx_s2) begin
          next_r.state = ST_MEAS_LOW;
          next_r.pre = 4'h1; // This first low clock counts as well
          next_r.div = '0;
        end
      end
      ST_MEAS_LOW: begin
        if (r.rx_s2) begin
          // A glitch gives no period; measure again
          if (r.div == '0) begin
            next_r.state = ST_MEAS_IDLE;
          end else begin
            next_r.tx_on = 1'b1;
            next_r = go_send(next_r, BYTE_ZERO, ST_WAIT_SYNC);
          end
        end else if (r.pre == 4'(LOW_BITS - 1)) begin
          // One divisor step per nine low clocks
          next_r.pre = '0;
          if (r.div != '1) begin
            next_r.div = r.div + 1'b1;
          end
        end else begin
          next_r.pre = r.pre + 1'b1;
        end
      end
      ST_SEND: begin
        if (!r.sent) begin
          next_r.tx_start = 1'b1;
          next_r.sent = 1'b1;
        end else if (!lk.tx_busy) begin
          next_r.state = r.ret;
          if (r.ret == ST_WAIT_SYNC) begin
            // Stale zero bytes before this point are dropped
            next_r.rx_on = 1'b1;
            next_r.pend = lk.rx_valid;
          end
          if (r.ret == ST_BRANCHED) begin
            next_r.rx_on = 1'b0;
            next_r.tx_on = 1'b0;
            next_r.branch = 1'b1;
          end
        end
      end
      ST_WAIT_SYNC: begin
        if (r.pend) begin
          next_r.pend = lk.rx_valid;
          if (r.pend_data == BYTE_SYNC) begin
            next_r = go_send(next_r, BYTE_ACK, ST_LEN_HI);
          end
        end
      end
      ST_LEN_HI: begin
        if (r.pend) begin
          next_r.pend = lk.rx_valid;
          next_r.len[15:8] = r.pend_data;
          next_r = go_send(next_r, r.pend_data, ST_LEN_LO);
        end
      end
      ST_LEN_LO: begin
        if (r.pend) begin
          next_r.pend = lk.rx_valid;
          next_r.len[7:0] = r.pend_data;
          next_r.idx = '0;
          next_r = go_send(next_r, r.pend_data,
                           ({r.len[15:8], r.pend_data} == '0) ? ST_CHECK
                                                              : ST_DATA);
        end
      end
      ST_DATA: begin
        if (r.pend) begin
          next_r.pend = lk.rx_valid;
          next_r.ram_addr = PROG_RAM_BASE + 24'(r.idx);
          next_r.ram_wdata = r.pend_data;
          // Bytes past the top are echoed, not stored
          next_r.ram_we = r.idx <= 16'(PROG_RAM_TOP - PROG_RAM_BASE);
          next_r.idx = r.idx + 1'b1;
          next_r = go_send(next_r, r.pend_data,
                           (r.idx + 1'b1 == r.len) ? ST_CHECK : ST_DATA);
        end
      end
      ST_CHECK: begin
        next_r.check = 1'b1;
        if (r.check && flash_check_done) begin
          next_r.check = 1'b0;
          if (flash_blank) begin
            next_r.flash_ok = 1'b1;
            next_r = go_send(next_r, BYTE_ACK, ST_BRANCHED);
          end else begin
            next_r.state = ST_ERASE;
            next_r.erase = 1'b1;
            next_r.irq_block = 1'b1;
          end
        end
      end
      ST_ERASE: begin
        if (flash_erase_done) begin
          next_r.erase = 1'b0;
          next_r.irq_block = 1'b0;
          if (flash_erase_ok) begin
            next_r.flash_ok = 1'b1;
            next_r = go_send(next_r, BYTE_ACK, ST_BRANCHED);
          end else begin
            next_r.fail = 1'b1;
            next_r = go_send(next_r, BYTE_FAIL, ST_HALT);
          end
        end
      end
      ST_NOT_BOOT, ST_HALT, ST_BRANCHED: begin
        // Rest here until the next reset
      end
      default: next_r.state = ST_HALT;
    endcase

    // Write channel: address and data in either order
    if (awvalid && r.awready) begin
      next_r.awready = 1'b0;
      next_r.aw_got = 1'b1;
      next_r.waddr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.wready = 1'b0;
      next_r.w_got = 1'b1;
      next_r.wd = wdata;
      next_r.ws = wstrb;
    end
    if (r.aw_got && r.w_got) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      rd = read_reg(r, r.waddr);
      next_r.bresp = rd[32] ? RESP_OKAY : RESP_DECERR;
      // Serial setup belongs to the loader until it branches
      if (r.state == ST_BRANCHED) begin
        if (r.waddr == ADDR_W'(REG_SERIAL_CTRL) && r.ws[0]) begin
          next_r.rx_on = r.wd[CTRL_RX_ON_BIT];
          next_r.tx_on = r.wd[CTRL_TX_ON_BIT];
        end
        if (r.waddr == ADDR_W'(REG_BAUD_DIV)) begin
          if (r.ws[0]) begin
            next_r.div[7:0] = r.wd[7:0];
          end
          if (r.ws[1]) begin
            next_r.div[15:8] = r.wd[15:8];
          end
        end
      end
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end
    // Read channel: one outstanding read
    if (arvalid && r.arready) begin
      rd = read_reg(r, araddr);
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rdata = rd[31:0];
      next_r.rresp = rd[32] ? RESP_OKAY : RESP_DECERR;
    end
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
  end

  // Watchdog overflow resets this loader state like the pin does; serial_rx and serial_tx reset on the pin only
  always_ff @(posedge aclk) begin
    if (!aresetn || watchdog_overflow) begin
      r <= '0;
      r.rx_s1 <= 1'b1;
      r.rx_s2 <= 1'b1;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce || watchdog_overflow);

  property p_startup;
    (r.state == ST_MEAS_IDLE && $past(r.state) == ST_STARTUP)
      |-> $past(r.cnt) == DIV_W'(STARTUP_CYCLES - 1);
  endproperty
  a_startup: assert property (p_startup)
    else $error("measurement began at wrong count");

  property p_prescale;
    r.state == ST_MEAS_LOW |-> r.pre < 4'(LOW_BITS);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler beyond nine");

  property p_zero;
    (r.state == ST_MEAS_LOW && r.rx_s2 && r.div != '0)
      |=> r.state == ST_SEND && r.tx_data == BYTE_ZERO ##1 r.tx_start;
  endproperty
  a_zero: assert property (p_zero)
    else $error("no zero byte after measurement");

  property p_sync_ack;
    (r.state == ST_WAIT_SYNC && r.pend && r.pend_data == BYTE_SYNC)
      |=> r.tx_data == BYTE_ACK && r.ret == ST_LEN_HI;
  endproperty
  a_sync_ack: assert property (p_sync_ack)
    else $error("0x55 not answered with 0xAA");

  property p_echo;
    (r.state == ST_DATA && r.pend)
      |=> r.tx_data == $past(r.pend_data) ##1 r.tx_start;
  endproperty
  a_echo: assert property (p_echo)
    else $error("program byte not echoed");

  property p_ram_range;
    r.ram_we |-> r.ram_addr >= PROG_RAM_BASE
      && r.ram_addr <= PROG_RAM_TOP;
  endproperty
  a_ram_range: assert property (p_ram_range)
    else $error("RAM write outside program area");

  property p_irq;
    r.erase |-> r.irq_block;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupts open during erase");

  property p_branch;
    $rose(r.branch) |-> r.flash_ok && !r.rx_on && !r.tx_on
      && r.div == $past(r.div) && txd_pin;
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch without clean exit");

  property p_fail;
    (r.state == ST_ERASE && flash_erase_done && !flash_erase_ok)
      |=> r.tx_data == BYTE_FAIL && r.ret == ST_HALT && !r.branch;
  endproperty
  a_fail: assert property (p_fail)
    else $error("erase failure not reported");
endmodule // serial_boot_loader
`default_nettype wire

// File: hw/serial_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// Loader to serial receiver and transmitter
interface serial_link_if;
  import boot_loader_pkg::*;
  logic [DIV_W-1:0] div; // Clocks per bit
  logic rx_on; // Receiver enable
  logic tx_on; // Transmitter enable
  logic rx_line; // Synchronised receive line
  logic rx_valid; // One-cycle byte pulse
  logic [7:0] rx_data;
  logic tx_start; // One-cycle send pulse
  logic [7:0] tx_data;
  logic tx_busy; // Frame in flight
  modport loader (output div, rx_on, tx_on, rx_line, tx_start, tx_data,
    input rx_valid, rx_data, tx_busy);
  modport rx (input div, rx_on, rx_line, output rx_valid, rx_data);
  modport tx (input div, tx_on, tx_start, tx_data, output tx_busy);
endinterface
`default_nettype wire

// File: hw/serial_rx.sv
`timescale 1ns/1ns
`default_nettype none
// Asynchronous receiver, 8 data bits, 1 stop, no parity
module serial_rx
  import boot_loader_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  serial_link_if.rx lk
);
  typedef struct packed {
    logic [1:0] ph; // 0 idle, 1 start, 2 data, 3 stop
    logic [DIV_W-1:0] cnt;
    logic [2:0] bitn;
    logic [7:0] shift;
    logic valid;
    logic [7:0] data;
  } rx_t;
  rx_t r;
  rx_t next_r;

  assign lk.rx_valid = r.valid;
  assign lk.rx_data = r.data;

  // Sample each bit mid-cell; bad stop bit drops the byte
  always_comb begin
    next_r = r;
    next_r.valid = 1'b0;
    case (r.ph)
      2'h0: begin
        if (lk.rx_on && !lk.rx_line) begin
          next_r.ph = 2'h1;
          next_r.cnt = lk.div >> 1;
        end
      end
      2'h1: begin
        if (r.cnt == '0) begin
          // False start if line is high again
          next_r.ph = lk.rx_line ? 2'h0 : 2'h2;
          next_r.cnt = lk.div - 1'b1;
          next_r.bitn = '0;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      2'h2: begin
        if (r.cnt == '0) begin
          next_r.shift = {lk.rx_line, r.shift[7:1]};
          next_r.cnt = lk.div - 1'b1;
          next_r.bitn = r.bitn + 1'b1;
          if (r.bitn == 3'h7) begin
            next_r.ph = 2'h3;
          end
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      default: begin
        if (r.cnt == '0) begin
          next_r.ph = 2'h0;
          next_r.valid = lk.rx_line;
          next_r.data = r.shift;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule // serial_rx
`default_nettype wire

// File: hw/serial_tx.sv
`timescale 1ns/1ns
`default_nettype none
// Asynchronous transmitter, 8 data bits, 1 stop, no parity
module serial_tx
  import boot_loader_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  serial_link_if.tx lk,
  output logic txd_pin
);
  typedef struct packed {
    logic busy;
    logic [DIV_W-1:0] cnt;
    logic [3:0] bitn;
    logic [9:0] shift;
    logic txd;
  } tx_t;
  tx_t r;
  tx_t next_r;

  // Start pulse counts as busy so the loader never misses it
  assign lk.tx_busy = r.busy | lk.tx_start;
  assign txd_pin = r.txd;

  // Start bit, eight data bits LSB first, one stop bit
  always_comb begin
    next_r = r;
    if (!r.busy) begin
      next_r.txd = 1'b1;
      if (lk.tx_on && lk.tx_start) begin
        next_r.busy = 1'b1;
        next_r.txd = 1'b0;
        next_r.shift = {2'h3, lk.tx_data};
        next_r.cnt = lk.div - 1'b1;
        next_r.bitn = '0;
      end
    end else if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end else if (r.bitn == 4'h9) begin
      next_r.busy = 1'b0; // Stop bit done, line idles high
    end else begin
      next_r.txd = r.shift[0];
      next_r.shift = {1'b1, r.shift[9:1]};
      next_r.bitn = r.bitn + 1'b1;
      next_r.cnt = lk.div - 1'b1;
    end
  end

  // Line idles high from reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.txd <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  property p_start_bit;
    @(posedge aclk) disable iff (!aresetn || !ce)
      (!r.busy && lk.tx_on && lk.tx_start) |=> !txd_pin && r.busy;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not driven low");
endmodule // serial_tx
`default_nettype wire

// File: verif/boot_host.sv
`timescale 1ns/1ns
`default_nettype none
// Far-side host: 8N1 frames, LSB first
module boot_host #(
  parameter int BIT = 104
) (
  input wire logic aclk,
  output logic rxd,
  input wire logic txd
);
  // Idle high, as the board pull-up leaves it
  initial rxd = 1'b1;
  // Start, eight data bits, one stop, no parity
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge aclk);
    end
  endtask
  // Bounded wait for a start bit, then mid-bit sampling
  task automatic get(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (txd !== 1'b0 && n < 40 * BIT) begin
      @(posedge aclk);
      n++;
    end
    if (n < 40 * BIT) begin
      repeat (BIT / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge aclk);
        b[i] = txd;
      end
      repeat (BIT) @(posedge aclk);
      ok = (txd === 1'b1); // Framing error leaves ok low
      // Let the stop bit end and the device act on it
      repeat (BIT / 2 + 2) @(posedge aclk);
    end
  endtask
endmodule // boot_host
`default_nettype wire

// File: verif/serial_boot_loader_tb.sv
`timescale 1ns/1ns
`default_nettype none
module serial_boot_loader_tb;
  import boot_loader_pkg::*;
  localparam int BIT = 104; // Fast host rate keeps the run short
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rxd_pin, txd_pin;
  logic [7:0] awaddr, araddr, last_data, ram_wdata;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] op_mode_pins;
  logic watchdog_overflow, flash_check_req, flash_check_done, flash_blank;
  logic flash_erase_req, flash_erase_done, flash_erase_ok, ram_we;
  logic [23:0] ram_addr, last_addr;
  logic branch_go, irq_block;
  int error_cnt, samples_checked, ram_cnt, er_cnt, erased;
  serial_boot_loader DUT (.aclk, .aresetn, .ce(1'b1), .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .rxd_pin, .txd_pin, .op_mode_pins, .watchdog_overflow,
    .flash_check_req, .flash_check_done, .flash_blank, .flash_erase_req,
    .flash_erase_done, .flash_erase_ok, .ram_we, .ram_addr, .ram_wdata,
    .branch_go, .irq_block);
  boot_host #(.BIT(BIT)) host (.aclk, .rxd(rxd_pin), .txd(txd_pin));
  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task give_verdict();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Flash stand-in: check answers next cycle, erase takes 21 cycles
  always @(posedge aclk) begin
    er_cnt <= flash_erase_req ? er_cnt + 1 : 0;
    flash_erase_done <= (er_cnt == 20);
    flash_check_done <= flash_check_req && !flash_check_done;
    if (ram_we) begin
      ram_cnt <= ram_cnt + 1;
      last_addr <= ram_addr;
      last_data <= ram_wdata;
    end
    if (er_cnt == 10) begin
      erased <= erased + 1;
      check("irq_block", 32'(irq_block), 32'h1);
      check("early branch", 32'(branch_go), 32'h0);
    end
  end
  // Write: address and data together, bready held until bvalid
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  task axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  // Optional send, overlapped with the awaited reply
  task xfer(input logic snd, input logic [7:0] t, input logic [7:0] e);
    logic [7:0] b;
    logic ok;
    fork
      if (snd) host.send(t);
      host.get(b, ok);
    join
    check("reply frame", 32'(ok), 32'h1);
    if (ok !== 1'b1) give_verdict();
    check("reply byte", 32'(b), 32'(e));
  endtask
  task boot(input logic [7:0] n, input logic [7:0] last);
    xfer(1'b1, BYTE_ZERO, BYTE_ZERO);
    xfer(1'b1, BYTE_SYNC, BYTE_ACK);
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b1, n, n);
    for (int i = 0; i < n; i++) xfer(1'b1, 8'h5A, 8'h5A);
    xfer(1'b0, 8'h00, last);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, watchdog_overflow} = '0;
    {flash_check_done, flash_erase_done, flash_blank} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {error_cnt, samples_checked, ram_cnt, er_cnt, erased} = '0;
    flash_erase_ok = 1'b1;
    op_mode_pins = BOOT_STRAPS;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h40);
    check("unmapped resp", 32'(r), 32'(RESP_DECERR));
    axi_wr(REG_BAUD_DIV, 32'h1234);
    check("early write resp", 32'(r), 32'(RESP_OKAY));
    repeat (110) @(posedge aclk);
    boot(8'h01, BYTE_ACK);
    check("erase runs", 32'(erased), 32'h1);
    check("ram writes", 32'(ram_cnt), 32'h1);
    check("ram addr", 32'(last_addr), 32'(PROG_RAM_BASE));
    check("ram data", 32'(last_data), 32'h5A);
    check("branch", 32'(branch_go), 32'h1);
    axi_rd(REG_SERIAL_CTRL);
    check("ctrl enables", 32'(d[1:0]), 32'h0);
    axi_rd(REG_BAUD_DIV);
    check("divisor", d, 32'(BIT));
    check("txd idle", 32'(txd_pin), 32'h1);
    // Enables belong to the loaded program once it runs
    axi_wr(REG_SERIAL_CTRL, 32'h3);
    axi_rd(REG_SERIAL_CTRL);
    check("ctrl after branch", 32'(d[1:0]), 32'h3);
    // Watchdog reset, then an erase that fails
    watchdog_overflow <= 1'b1;
    flash_erase_ok <= 1'b0;
    repeat (2) @(posedge aclk);
    watchdog_overflow <= 1'b0;
    @(posedge aclk);
    check("branch cleared", 32'(branch_go), 32'h0);
    repeat (110) @(posedge aclk);
    boot(8'h00, BYTE_FAIL);
    axi_rd(REG_STATUS);
    check("fail flag", 32'(d[STAT_FAIL_BIT]), 32'h1);
    check("no branch", 32'(branch_go), 32'h0);
    // Other straps: loader stays out of boot
    aresetn <= 1'b0;
    op_mode_pins <= 3'h7;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (110) @(posedge aclk);
    axi_rd(REG_STATUS);
    check("not boot", 32'(d[3:0]), 32'h1);
    give_verdict();
  end
endmodule // serial_boot_loader_tb
`default_nettype wire
